// ### core/acq_timing_pkg.sv
package acq_timing_pkg;

  // Pins and widths
  localparam int          PIN_COUNT   = 10;
  localparam int          PIN_SEL_W   = 4;
  localparam int          CNT_W       = 24;
  localparam int          CLK_MHZ     = 100;

  // Register byte offsets
  localparam logic [11:0] ADDR_AI_CFG   = 12'h000;
  localparam logic [11:0] ADDR_AO_CFG   = 12'h004;
  localparam logic [11:0] ADDR_SAMP_DIV = 12'h008;
  localparam logic [11:0] ADDR_SCAN_DIV = 12'h00c;
  localparam logic [11:0] ADDR_LOAD_DIV = 12'h010;
  localparam logic [11:0] ADDR_OUT_EN   = 12'h014;
  localparam logic [11:0] ADDR_CMD      = 12'h018;
  localparam logic [11:0] ADDR_STATUS   = 12'h01c;

  // AI config field positions
  localparam int CONV_SEL_LSB  = 0;
  localparam int CONV_POL_BIT  = 4;
  localparam int CONV_EXT_BIT  = 5;
  localparam int GATE_SEL_LSB  = 8;
  localparam int GATE_POL_BIT  = 12;
  localparam int GATE_EDGE_BIT = 13;
  localparam int GATE_HW_BIT   = 14;
  localparam int SI_SEL_LSB    = 16;
  localparam int SI_POL_BIT    = 20;
  localparam int SI_EXT_BIT    = 21;
  localparam int SI_SLOW_BIT   = 22;
  localparam int SCAN_LEN_LSB  = 24;

  // AO config field positions
  localparam int TRIG_SEL_LSB  = 0;
  localparam int TRIG_POL_BIT  = 4;
  localparam int LOAD_SEL_LSB  = 8;
  localparam int LOAD_POL_BIT  = 12;
  localparam int LOAD_EXT_BIT  = 13;
  localparam int POSTED_BIT    = 14;
  localparam int UI_SEL_LSB    = 16;
  localparam int UI_POL_BIT    = 20;
  localparam int UI_EXT_BIT    = 21;
  localparam int UI_SLOW_BIT   = 22;

  // Command bits
  localparam int CMD_SEQ_START = 0;
  localparam int CMD_SEQ_STOP  = 1;
  localparam int CMD_SW_GATE   = 2;
  localparam int CMD_AO_STOP   = 3;
  localparam int CMD_AO_GATE   = 4;
  localparam int CMD_BUF_END   = 5;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Pulse widths in ns and the derived cycle counts
  localparam int CONV_PULSE_NS = 100;
  localparam int TRIG_PULSE_NS = 70;
  localparam int LOAD_PULSE_NS = 320;
  localparam int CONV_PULSE_CYC = (CONV_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS * CLK_MHZ + 999) / 1000;

  // Timebase dividers: 20 MHz and 100 kHz
  localparam int FAST_TB_CYC = CLK_MHZ / 20;
  localparam int SLOW_TB_CYC = CLK_MHZ * 10;

endpackage

// ### core/pin_event_detect.sv
`timescale 1ns/1ps
`default_nettype none
module pin_event_detect
  import acq_timing_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic [PIN_COUNT-1:0] pinSync,
  input  wire logic [PIN_SEL_W-1:0] pinSel,
  input  wire logic                 invert,
  output logic                      level,
  output logic                      edgePulse
);

  logic levelQ_q;
  wire  picked = (pinSel < PIN_SEL_W'(PIN_COUNT)) ? pinSync[pinSel] : 1'b0;
  wire  polar  = picked ^ invert; // RQ24

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      levelQ_q <= 1'b0;
    end else begin
      levelQ_q <= polar;
    end
  end

  assign level     = levelQ_q;
  assign edgePulse = polar & ~levelQ_q; // RQ24

endmodule // pin_event_detect
`default_nettype wire

// ### core/pulse_stretch.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_stretch #(
  parameter int WIDTH_CYC = 1
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic fire,
  output logic      active
);

  logic [7:0] count_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      count_q <= 8'h00;
    end else if (fire) begin
      count_q <= 8'(WIDTH_CYC);
    end else if (count_q != 8'h00) begin
      count_q <= count_q - 8'h01;
    end
  end

  assign active = (count_q != 8'h00);

endmodule // pulse_stretch
`default_nettype wire

// ### core/acq_waveform_timing.sv
// Summary of operation
// RQ1: Any pin, chosen edge, starts one conversion
// RQ2: External convert edges at least 5 us apart
// RQ3: Convert output mirrors applied strobe, active low
// RQ4: Monitored outputs tristated until software enables
// RQ5: Sample counter makes strobes, reloads per scan
// RQ6: No conversions outside an acquisition sequence
// RQ7: Scans gated by hardware or software gate
// RQ8: Gate from any pin, level/edge, polarity
// RQ9: Level mode: active gate blocks scan starts
// RQ10: Edge mode: gate edges toggle scan enable
// RQ11: Gate changes apply only at scan boundary
// RQ12: Scan interval clock times scan starts
// RQ13: External clocks at most 20 MHz
// RQ14: Internal timebase 20 MHz or 100 kHz
// RQ15: Trigger edge starts waveform and load counter
// RQ16: Trigger output mirrors real trigger, active high
// RQ17: Load strobe acts only in posted mode
// RQ18: Load output mirrors applied pulse, active low
// RQ19: DAC loads within 100 ns of strobe
// RQ20: Load counter starts on trigger, stops on command
// RQ21: Software gate suppresses every load strobe
// RQ22: Load interval clock times load strobes
// RQ23: Strobes blocked until scan start occurs
// RQ24: Inputs synchronised and polarity set first
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module acq_waveform_timing
  import acq_timing_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [PIN_COUNT-1:0] prog_function_pin,
  input  wire logic                 scan_begin_pulse,
  output logic                      convStrobe,
  output logic                      dacLoad,
  output logic                      convOut,
  output logic                      convOe_b,
  output logic                      trigOut,
  output logic                      trigOe_b,
  output logic                      loadOut,
  output logic                      loadOe_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0]          aiCfg_q, aoCfg_q, outEn_q;
  logic [CNT_W-1:0]     sampDiv_q, scanDiv_q, loadDiv_q;
  logic                 seqActive_q, swGate_q, aoGate_q, aoRun_q;
  logic [PIN_COUNT-1:0] pinMeta_q, pinSync_q;

  wire apbWrite = psel & penable & pwrite;
  wire cmdWrite = apbWrite & (paddr == ADDR_CMD);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  wire addrOk = hit(paddr, ADDR_AI_CFG) | hit(paddr, ADDR_AO_CFG) |
                hit(paddr, ADDR_SAMP_DIV) | hit(paddr, ADDR_SCAN_DIV) |
                hit(paddr, ADDR_LOAD_DIV) | hit(paddr, ADDR_OUT_EN) |
                hit(paddr, ADDR_CMD) | hit(paddr, ADDR_STATUS);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addrOk;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      aiCfg_q   <= RESET_WORD;
      aoCfg_q   <= RESET_WORD;
      outEn_q   <= RESET_WORD; // RQ4
      sampDiv_q <= CNT_W'(RESET_WORD);
      scanDiv_q <= CNT_W'(RESET_WORD);
      loadDiv_q <= CNT_W'(RESET_WORD);
      swGate_q  <= 1'b0;
      aoGate_q  <= 1'b0;
    end else if (apbWrite) begin
      if (hit(paddr, ADDR_AI_CFG))   aiCfg_q   <= pwdata;
      if (hit(paddr, ADDR_AO_CFG))   aoCfg_q   <= pwdata;
      if (hit(paddr, ADDR_OUT_EN))   outEn_q   <= pwdata;
      if (hit(paddr, ADDR_SAMP_DIV)) sampDiv_q <= pwdata[CNT_W-1:0];
      if (hit(paddr, ADDR_SCAN_DIV)) scanDiv_q <= pwdata[CNT_W-1:0];
      if (hit(paddr, ADDR_LOAD_DIV)) loadDiv_q <= pwdata[CNT_W-1:0];
      if (cmdWrite) begin
        swGate_q <= pwdata[CMD_SW_GATE];
        aoGate_q <= pwdata[CMD_AO_GATE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and event detectors

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= prog_function_pin; // RQ24
      pinSync_q <= pinMeta_q;
    end
  end

  logic convLvl, convEdge, gateLvl, gateEdge, siLvl, siEdge;
  logic trigLvl, trigEdge, loadLvl, loadEdge, uiLvl, uiEdge;

  pin_event_detect uConv (.clk_sys(clk_sys), .rst_b(rst_b),
    .pinSync(pinSync_q), .pinSel(aiCfg_q[CONV_SEL_LSB+:PIN_SEL_W]),
    .invert(aiCfg_q[CONV_POL_BIT]), .level(convLvl), .edgePulse(convEdge));
  pin_event_detect uGate (.clk_sys(clk_sys), .rst_b(rst_b), // RQ8
    .pinSync(pinSync_q), .pinSel(aiCfg_q[GATE_SEL_LSB+:PIN_SEL_W]),
    .invert(aiCfg_q[GATE_POL_BIT]), .level(gateLvl), .edgePulse(gateEdge));
  pin_event_detect uSi (.clk_sys(clk_sys), .rst_b(rst_b),
    .pinSync(pinSync_q), .pinSel(aiCfg_q[SI_SEL_LSB+:PIN_SEL_W]),
    .invert(aiCfg_q[SI_POL_BIT]), .level(siLvl), .edgePulse(siEdge));
  pin_event_detect uTrig (.clk_sys(clk_sys), .rst_b(rst_b),
    .pinSync(pinSync_q), .pinSel(aoCfg_q[TRIG_SEL_LSB+:PIN_SEL_W]),
    .invert(aoCfg_q[TRIG_POL_BIT]), .level(trigLvl), .edgePulse(trigEdge));
  pin_event_detect uLoad (.clk_sys(clk_sys), .rst_b(rst_b),
    .pinSync(pinSync_q), .pinSel(aoCfg_q[LOAD_SEL_LSB+:PIN_SEL_W]),
    .invert(aoCfg_q[LOAD_POL_BIT]), .level(loadLvl), .edgePulse(loadEdge));
  pin_event_detect uUi (.clk_sys(clk_sys), .rst_b(rst_b),
    .pinSync(pinSync_q), .pinSel(aoCfg_q[UI_SEL_LSB+:PIN_SEL_W]),
    .invert(aoCfg_q[UI_POL_BIT]), .level(uiLvl), .edgePulse(uiEdge));

  ////////////////////////////////////////////////////////////////////////////
  // Internal timebase ticks

  logic [9:0] fastCnt_q, slowCnt_q;
  wire fastTick = (fastCnt_q == 10'(FAST_TB_CYC - 1));
  wire slowTick = (slowCnt_q == 10'(SLOW_TB_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fastCnt_q <= 10'h000;
      slowCnt_q <= 10'h000;
    end else begin
      fastCnt_q <= fastTick ? 10'h000 : fastCnt_q + 10'h001;
      slowCnt_q <= slowTick ? 10'h000 : slowCnt_q + 10'h001;
    end
  end

  // Level-mode external clock: count its active-going transition
  wire siTick = aiCfg_q[SI_EXT_BIT] ? siEdge : // RQ12
                (aiCfg_q[SI_SLOW_BIT] ? slowTick : fastTick); // RQ14
  wire uiTick = aoCfg_q[UI_EXT_BIT] ? uiEdge : // RQ22
                (aoCfg_q[UI_SLOW_BIT] ? slowTick : fastTick); // RQ14

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition sequence, scan gate and scan start

  logic [CNT_W-1:0] scanCnt_q, sampCnt_q;
  logic [7:0]       convLeft_q;
  logic             gateToggle_q, inScan_q;

  wire seqStart = cmdWrite & pwdata[CMD_SEQ_START];
  wire seqStop  = cmdWrite & pwdata[CMD_SEQ_STOP];
  wire hwBlock  = aiCfg_q[GATE_HW_BIT] &
                  (aiCfg_q[GATE_EDGE_BIT] ? gateToggle_q : gateLvl); // RQ9
  wire gateBlock = hwBlock | swGate_q; // RQ7
  wire scanTimer = seqActive_q & siTick & (scanCnt_q == '0);
  // Gate is only sampled when a scan would begin, never mid-scan
  wire scanStart = seqActive_q & ~inScan_q & ~gateBlock & // RQ11
                   (scanTimer | scan_begin_pulse);

  wire extConv  = aiCfg_q[CONV_EXT_BIT];
  wire sampTick = inScan_q & ~extConv & (sampCnt_q == '0); // RQ5
  wire convFire = seqActive_q & inScan_q & // RQ6
                  (extConv ? convEdge : sampTick); // RQ1 RQ23
  wire lastConv = convFire & (convLeft_q == 8'h01);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      seqActive_q  <= 1'b0;
      gateToggle_q <= 1'b0;
      inScan_q     <= 1'b0;
      scanCnt_q    <= '0;
      sampCnt_q    <= '0;
      convLeft_q   <= 8'h00;
    end else begin
      seqActive_q <= (seqActive_q | seqStart) & ~seqStop;
      if (gateEdge) gateToggle_q <= ~gateToggle_q; // RQ10
      if (siTick) scanCnt_q <= (scanCnt_q == '0) ? scanDiv_q
                                                  : scanCnt_q - 1'b1;
      if (scanStart) begin
        inScan_q   <= 1'b1;
        sampCnt_q  <= sampDiv_q; // RQ5
        convLeft_q <= aiCfg_q[SCAN_LEN_LSB+:8];
      end else if (!seqActive_q || lastConv) begin
        inScan_q  <= 1'b0;
        sampCnt_q <= sampDiv_q; // RQ5
      end else if (inScan_q) begin
        // A length of zero never counts down, so the scan runs until stop
        if (convFire && convLeft_q != 8'h00) convLeft_q <= convLeft_q - 8'h01;
        if (sampTick) sampCnt_q <= sampDiv_q;
        else if (siTick) sampCnt_q <= sampCnt_q - 1'b1;
      end
    end
  end

  assign convStrobe = convFire;

  ////////////////////////////////////////////////////////////////////////////
  // Waveform trigger and DAC loads

  wire aoStop   = cmdWrite & (pwdata[CMD_AO_STOP] | pwdata[CMD_BUF_END]);
  wire trigFire = trigEdge & ~aoRun_q; // RQ15
  wire extLoad  = aoCfg_q[LOAD_EXT_BIT];
  logic [CNT_W-1:0] loadCnt_q;
  wire intLoad  = aoRun_q & uiTick & (loadCnt_q == '0); // RQ20
  wire loadFire = aoCfg_q[POSTED_BIT] & ~aoGate_q & // RQ17 RQ21
                  (extLoad ? loadEdge : intLoad);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      aoRun_q   <= 1'b0;
      loadCnt_q <= '0;
    end else begin
      // A trigger in the cycle of a stop wins, so trigOut never lies
      if (trigFire) aoRun_q <= 1'b1;
      else if (aoStop) aoRun_q <= 1'b0; // RQ20
      if (trigFire) loadCnt_q <= loadDiv_q; // RQ15
      else if (aoRun_q && uiTick)
        loadCnt_q <= (loadCnt_q == '0) ? loadDiv_q : loadCnt_q - 1'b1;
    end
  end

  // Combinational so the DAC sees the load in the same cycle
  assign dacLoad = loadFire; // RQ19

  ////////////////////////////////////////////////////////////////////////////
  // Monitored outputs

  logic convAct, trigAct, loadAct;
  pulse_stretch #(.WIDTH_CYC(CONV_PULSE_CYC)) uConvP (.clk_sys(clk_sys),
    .rst_b(rst_b), .fire(convFire), .active(convAct));
  pulse_stretch #(.WIDTH_CYC(TRIG_PULSE_CYC)) uTrigP (.clk_sys(clk_sys),
    .rst_b(rst_b), .fire(trigFire), .active(trigAct));
  pulse_stretch #(.WIDTH_CYC(LOAD_PULSE_CYC)) uLoadP (.clk_sys(clk_sys),
    .rst_b(rst_b), .fire(loadFire), .active(loadAct));

  assign convOut  = ~convAct; // RQ3
  assign trigOut  = trigAct; // RQ16
  assign loadOut  = ~loadAct; // RQ18
  assign convOe_b = ~outEn_q[0]; // RQ4
  assign trigOe_b = ~outEn_q[1];
  assign loadOe_b = ~outEn_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  wire [31:0] status = {26'h0, gateBlock, gateToggle_q, aoRun_q,
                        inScan_q, seqActive_q, swGate_q};
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (1'b1)
        hit(paddr, ADDR_AI_CFG):   prdata <= aiCfg_q;
        hit(paddr, ADDR_AO_CFG):   prdata <= aoCfg_q;
        hit(paddr, ADDR_SAMP_DIV): prdata <= 32'(sampDiv_q);
        hit(paddr, ADDR_SCAN_DIV): prdata <= 32'(scanDiv_q);
        hit(paddr, ADDR_LOAD_DIV): prdata <= 32'(loadDiv_q);
        hit(paddr, ADDR_OUT_EN):   prdata <= outEn_q;
        hit(paddr, ADDR_STATUS):   prdata <= status;
        default:                   prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  no_conv_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !seqActive_q |-> !convStrobe) else $error("convert outside sequence"); // RQ6
  conv_pin_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    convStrobe |=> !convOut [*2]) else $error("convert pulse short"); // RQ3
  trig_pin_high_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    trigFire |=> trigOut) else $error("trigger pulse missing"); // RQ16
  load_pin_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    dacLoad |=> !loadOut [*8]) else $error("load pulse short"); // RQ18
  gate_blocks_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    aoGate_q |-> !dacLoad) else $error("load while gated"); // RQ21
  posted_only_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !aoCfg_q[POSTED_BIT] |-> !dacLoad) else $error("load not posted"); // RQ17
  gate_blocks_scan_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    gateBlock |=> !$rose(inScan_q)) else $error("scan under gate"); // RQ9
  no_strobe_preScan_a: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    !inScan_q |-> !convStrobe) else $error("strobe before scan"); // RQ23
  tristate_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(rst_b) |-> convOe_b && trigOe_b && loadOe_b)
    else $error("output driven at start"); // RQ4
  scan_runs_on_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    inScan_q && seqActive_q && !lastConv |=> inScan_q)
    else $error("scan cut short"); // RQ11
  gate_edge_flip_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    gateEdge |=> gateToggle_q != $past(gateToggle_q))
    else $error("gate edge lost"); // RQ10
  trig_run_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    trigFire |=> aoRun_q) else $error("trigger did not start"); // RQ15
  stop_run_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    aoStop && !trigFire |=> !aoRun_q) else $error("run after stop"); // RQ20

endmodule // acq_waveform_timing
`default_nettype wire

// ### dv/ext_instrument.sv
`timescale 1ns/1ps
`default_nettype none
module ext_instrument
  import acq_timing_pkg::*;
(
  input  wire logic                 clk_sys,
  output var  logic [PIN_COUNT-1:0] pins
);
  time lastEdge = 0;
  initial pins = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Every pulse is spaced by the strobe limit, simpler than a per-pin rule
  task automatic pulse(input int idx);
    @(posedge clk_sys);
    while ($time < lastEdge + 5000) @(posedge clk_sys);
    pins[idx] <= 1'b1;
    lastEdge = $time;
    repeat (3) @(posedge clk_sys);
    pins[idx] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic setLevel(input int idx, input logic val);
    @(posedge clk_sys);
    pins[idx] <= val;
  endtask
endmodule // ext_instrument
`default_nettype wire

// ### dv/acq_waveform_timing_bench.sv
`timescale 1ns/1ps
`default_nettype none
module acq_waveform_timing_bench
  import acq_timing_pkg::*;
;
  logic                 clk_sys, rst_b, psel, penable, pwrite, scanBegin;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rdata;
  logic                 pready, pslverr, rerr, convStrobe, dacLoad;
  logic                 convOut, convOe_b, trigOut, trigOe_b, loadOut, loadOe_b;
  logic [PIN_COUNT-1:0] pins;
  int                   errCount, nTests, nConv, nLoad, c0;
  int                   convRun, convW, trigRun, trigW, loadRun, loadW;
  // Fast internal scan clock; a huge scan divider keeps timed scans away
  localparam logic [31:0] SI_OFF  = 32'h0;
  localparam logic [31:0] SI_PIN9 = (32'h9 << SI_SEL_LSB) |
                                    (32'h1 << SI_EXT_BIT);
  localparam logic [31:0] GATE5   = (32'h5 << GATE_SEL_LSB) |
                                    (32'h1 << GATE_HW_BIT);
  localparam logic [31:0] GATE4   = (32'h4 << GATE_SEL_LSB) |
                                    (32'h1 << GATE_HW_BIT);
  localparam logic [31:0] AO_POST = 32'h1 | (32'h1 << POSTED_BIT);

  acq_waveform_timing dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_function_pin(pins), .scan_begin_pulse(scanBegin),
    .convStrobe(convStrobe), .dacLoad(dacLoad), .convOut(convOut),
    .convOe_b(convOe_b), .trigOut(trigOut), .trigOe_b(trigOe_b),
    .loadOut(loadOut), .loadOe_b(loadOe_b));
  ext_instrument inst (.clk_sys(clk_sys), .pins(pins));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (convStrobe === 1'b1) nConv++;
    if (dacLoad === 1'b1) nLoad++;
    if (convOut === 1'b0) convRun++;
    else if (convRun > 0) begin convW = convRun; convRun = 0; end
    if (trigOut === 1'b1) trigRun++;
    else if (trigRun > 0) begin trigW = trigRun; trigRun = 0; end
    if (loadOut === 1'b0) loadRun++;
    else if (loadRun > 0) begin loadW = loadRun; loadRun = 0; end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string msg);
    nTests++;
    if (!ok) begin
      errCount++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic pulseScan;
    @(posedge clk_sys);
    scanBegin <= 1'b1;
    @(posedge clk_sys);
    scanBegin <= 1'b0;
  endtask
  task automatic giveVerdict;
    $display("mismatches %0d, comparisons %0d", errCount, nTests);
    if (errCount == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic testReset;
    chk(convOe_b === 1 && trigOe_b === 1 && loadOe_b === 1, "oe at reset");
    chk(convOut === 1 && loadOut === 1 && trigOut === 0, "idle levels");
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rdata === 32'h0 && rerr === 1'b0, "reset read");
    end
    apb(1'b1, 12'hfe0, 32'hffff_ffff);
    chk(rerr === 1'b1, "unmapped write accepted");
    apb(1'b0, 12'hfe0, 32'h0);
    chk(rdata === 32'h0 && rerr === 1'b1, "unmapped read");
    apb(1'b1, ADDR_SAMP_DIV, 32'h00ab_cdef);
    apb(1'b0, ADDR_SAMP_DIV, 32'h0);
    chk(rdata === 32'h00ab_cdef, "divider readback");
  endtask
  task automatic testExtClocks;
    apb(1'b1, ADDR_AI_CFG, SI_PIN9 | (32'h1 << SCAN_LEN_LSB));
    apb(1'b1, ADDR_SCAN_DIV, 32'h1);
    apb(1'b1, ADDR_SAMP_DIV, 32'h0);
    apb(1'b1, ADDR_CMD, 32'h1);
    c0 = nConv;
    repeat (3) inst.pulse(9);
    idle(20);
    chk(nConv == c0 + 2, "scan clock from pin");
    apb(1'b1, ADDR_CMD, 32'h2);
  endtask
  task automatic testInternal;
    apb(1'b1, ADDR_SCAN_DIV, 32'h00ff_ffff);
    apb(1'b1, ADDR_SAMP_DIV, 32'h9);
    apb(1'b1, ADDR_AI_CFG, SI_OFF | (32'h2 << SCAN_LEN_LSB));
    apb(1'b1, ADDR_OUT_EN, 32'h1);
    c0 = nConv;
    pulseScan; idle(300);
    chk(nConv == c0, "conversion outside sequence");
    apb(1'b1, ADDR_CMD, 32'h1); idle(50);
    chk(nConv == c0, "conversion before scan start");
    pulseScan; idle(400);
    chk(nConv == c0 + 2, "scan conversion count");
    chk(convW == CONV_PULSE_CYC, "convert pulse width");
    chk(convOe_b === 1'b0, "convert pin not driven");
    pulseScan; idle(400);
    chk(nConv == c0 + 4, "count after reload");
    apb(1'b1, ADDR_CMD, 32'ha);
  endtask
  task automatic testExternal;
    apb(1'b1, ADDR_AI_CFG, SI_OFF | (32'h2 << SCAN_LEN_LSB) |
        (32'h3 << CONV_SEL_LSB) | (32'h1 << CONV_EXT_BIT));
    apb(1'b1, ADDR_CMD, 32'h1);
    c0 = nConv;
    inst.pulse(3); idle(20);
    chk(nConv == c0, "external strobe before scan");
    pulseScan; inst.pulse(3); inst.pulse(3); idle(20);
    chk(nConv == c0 + 2, "external strobes lost");
    chk(convW == CONV_PULSE_CYC, "mirrored pulse width");
    inst.pulse(3); idle(20);
    chk(nConv == c0 + 2, "strobe after scan end");
    apb(1'b1, ADDR_CMD, 32'ha);
  endtask
  task automatic testLevelGate;
    inst.setLevel(5, 1'b1);
    apb(1'b1, ADDR_AI_CFG, SI_OFF | GATE5 | (32'h1 << SCAN_LEN_LSB));
    apb(1'b1, ADDR_CMD, 32'h1);
    c0 = nConv;
    pulseScan; idle(200);
    chk(nConv == c0, "scan under level gate");
    inst.setLevel(5, 1'b0); idle(10);
    pulseScan; idle(200);
    chk(nConv == c0 + 1, "scan blocked, gate idle");
    apb(1'b1, ADDR_AI_CFG, SI_OFF | GATE5 | (32'h1 << SCAN_LEN_LSB) |
        (32'h1 << GATE_POL_BIT));
    idle(10); pulseScan; idle(200);
    chk(nConv == c0 + 1, "inverted gate ignored");
    apb(1'b1, ADDR_CMD, 32'ha);
  endtask
  task automatic testEdgeGate;
    apb(1'b1, ADDR_AI_CFG, SI_OFF | GATE4 | (32'h1 << GATE_EDGE_BIT));
    apb(1'b1, ADDR_CMD, 32'h1);
    inst.pulse(4); idle(10);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdata[4] === 1'b1, "first gate edge");
    c0 = nConv;
    pulseScan; idle(200);
    chk(nConv == c0, "scan after blocking edge");
    inst.pulse(4); idle(10);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdata[4] === 1'b0, "second gate edge");
    // Endless scan: a blocking edge in mid-scan must not stop it
    pulseScan; inst.pulse(4);
    c0 = nConv;
    idle(200);
    chk(nConv >= c0 + 3, "gate stopped running scan");
    apb(1'b1, ADDR_CMD, 32'ha);
  endtask
  task automatic testSwGate;
    apb(1'b1, ADDR_AI_CFG, SI_OFF | (32'h1 << SCAN_LEN_LSB));
    apb(1'b1, ADDR_CMD, 32'h5);
    c0 = nConv;
    pulseScan; idle(200);
    chk(nConv == c0, "scan under software gate");
    apb(1'b1, ADDR_CMD, 32'h1);
    pulseScan; idle(200);
    chk(nConv == c0 + 1, "scan after gate release");
    apb(1'b1, ADDR_CMD, 32'ha);
  endtask
  task automatic testWave;
    apb(1'b1, ADDR_LOAD_DIV, 32'h13);
    apb(1'b1, ADDR_AO_CFG, AO_POST);
    apb(1'b1, ADDR_OUT_EN, 32'h7);
    c0 = nLoad;
    inst.pulse(1); idle(350);
    chk(nLoad >= c0 + 2 && nLoad <= c0 + 4, "load count");
    chk(trigW == TRIG_PULSE_CYC, "trigger pulse width");
    chk(loadW == LOAD_PULSE_CYC, "load pulse width");
    chk(trigOe_b === 1'b0 && loadOe_b === 1'b0, "pins not driven");
    apb(1'b1, ADDR_CMD, 32'h8);
    c0 = nLoad;
    idle(300);
    chk(nLoad == c0, "load after stop");
    apb(1'b1, ADDR_CMD, 32'h10);
    inst.pulse(1); idle(300);
    chk(nLoad == c0, "load under software gate");
    apb(1'b1, ADDR_CMD, 32'h8);
    apb(1'b1, ADDR_AO_CFG, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h0);
    inst.pulse(1); idle(300);
    chk(nLoad == c0, "load outside posted mode");
    apb(1'b1, ADDR_CMD, 32'h8);
    apb(1'b1, ADDR_AO_CFG, AO_POST);
    apb(1'b1, ADDR_CMD, 32'h0);
    inst.pulse(1); idle(150);
    apb(1'b1, ADDR_CMD, 32'h20);
    c0 = nLoad;
    idle(300);
    chk(nLoad == c0, "load after buffer end");
    apb(1'b1, ADDR_LOAD_DIV, 32'h1);
    apb(1'b1, ADDR_AO_CFG, AO_POST | (32'h7 << UI_SEL_LSB) |
        (32'h1 << UI_EXT_BIT));
    inst.pulse(1);
    c0 = nLoad;
    repeat (2) inst.pulse(7);
    idle(20);
    chk(nLoad == c0 + 1, "load clock from pin");
    apb(1'b1, ADDR_CMD, 32'h8);
    apb(1'b1, ADDR_AO_CFG, AO_POST | (32'h8 << LOAD_SEL_LSB) |
        (32'h1 << LOAD_EXT_BIT));
    c0 = nLoad;
    inst.pulse(8);
    idle(50);
    chk(nLoad == c0 + 1, "external load lost");
    chk(loadW == LOAD_PULSE_CYC, "mirrored load width");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; scanBegin = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    testReset;
    testExtClocks;
    testInternal;
    testExternal;
    testLevelGate;
    testEdgeGate;
    testSwGate;
    testWave;
    giveVerdict;
  end
  // About 10k cycles expected; six times that means a hang
  initial begin
    repeat (60000) @(posedge clk_sys);
    errCount++;
    giveVerdict;
  end
endmodule // acq_waveform_timing_bench
`default_nettype wire
